/* File: inc/exec_pkg.sv */
// Constants and types shared by the branch, call, compare and flag-clear unit
package exec_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL  = 8'h00;
    localparam logic [7:0]  REG_INSTR = 8'h04;
    localparam logic [7:0]  REG_EA    = 8'h08;
    localparam logic [7:0]  REG_ACC   = 8'h0C;
    localparam logic [7:0]  REG_CCR   = 8'h10;
    localparam logic [7:0]  REG_PC    = 8'h14;
    localparam logic [7:0]  REG_SP    = 8'h18;
    localparam logic [7:0]  REG_PAGE  = 8'h1C;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int          CTRL_START = 0;
    localparam int          CTRL_XMEM  = 1;
    localparam int          CTRL_IND   = 2;
    localparam int          CTRL_LEN_L = 4;
    localparam int          CTRL_LEN_H = 6;
    localparam int          CTRL_BUSY  = 8;
    localparam int          CTRL_ERR   = 9;

    // ------------------------------------------------------------------
    // Condition code register bits and reset value
    // ------------------------------------------------------------------
    localparam int          CCR_C = 0;
    localparam int          CCR_V = 1;
    localparam int          CCR_Z = 2;
    localparam int          CCR_N = 3;
    localparam int          CCR_I = 4;
    localparam logic [7:0]  CCR_RST = 8'hD0;

    // ------------------------------------------------------------------
    // Object code
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_BR_OVF   = 8'h29;
    localparam logic [7:0]  OP_PREFIX   = 8'h18;
    localparam logic [7:0]  OP_CMP_AB   = 8'h17;
    localparam logic [7:0]  OP_FLAG_AND = 8'h10;
    localparam logic [7:0]  OP_CALL_EXT = 8'h4A;
    localparam logic [7:0]  OP_CALL_IDX = 8'h4B;
    localparam logic [15:0] BR_STEP     = 16'h0002;
    localparam logic [15:0] INH2_STEP   = 16'h0002;
    localparam logic [15:0] IMM_STEP    = 16'h0002;
    localparam logic [15:0] CALL_EXT_LEN = 16'h0004;
    localparam logic [15:0] RTN_BYTES   = 16'h0002;
    localparam logic [15:0] PAGE_BYTES  = 16'h0001;
    localparam logic [15:0] PTR_NEXT    = 16'h0001;
    localparam logic [15:0] PTR_PAGE    = 16'h0002;

    // Byte positions within the instruction word
    localparam int          B_OP = 0;
    localparam int          B_1  = 1;
    localparam int          B_2  = 2;
    localparam int          B_3  = 3;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_EXEC, ST_IND_HI, ST_IND_LO, ST_IND_PG,
        ST_PUSH_H, ST_PUSH_L, ST_PUSH_P
    } state_type;

endpackage

/* File: hw/exec_unit.sv */
// Execution unit for overflow branch, paged call, accumulator compare and flag clears
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module exec_unit
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    // Stack and data memory
    output logic             o_mem_req,
    output logic             o_mem_we,
    output logic [15:0]      o_mem_addr,
    output logic [7:0]       o_mem_wdata,
    input  wire logic        i_mem_ack,
    input  wire logic [7:0]  i_mem_rdata,
    // Interrupt gating and status
    input  wire logic        i_irq_pending,
    output logic             o_irq_grant,
    output logic             o_done
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        state_type   st;
        logic [31:0] instr;
        logic [23:0] ea;
        logic [7:0]  acc_a;
        logic [7:0]  acc_b;
        logic [7:0]  condition_code_register;
        logic [7:0]  page;
        logic [7:0]  pg_new;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] rtn;
        logic [15:0] tgt;
        logic        xmem;
        logic        ind;
        logic [2:0]  len;
        logic        err;
        logic        mask_dly;
        logic        irq_hold;
        logic        grant;
        logic        done;
        logic        mem_req;
        logic        mem_we;
        logic [15:0] mem_addr;
        logic [7:0]  mem_wdata;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } core_type;
    core_type    q;
    core_type    d;
    logic [31:0] rd_word;
    logic        hit;
    logic        busy;
    logic        apb_acc;
    logic        mem_fin;
    logic [7:0]  opc;
    logic [7:0]  b1;
    logic [7:0]  diff;
    function automatic logic [7:0] byte_of(input logic [31:0] w, input int idx);
        byte_of = w[idx*8 +: 8];
    endfunction
    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d       = q;
        busy    = (q.st != ST_IDLE);
        apb_acc = i_psel & i_penable;
        mem_fin = q.mem_req & i_mem_ack;
        opc     = byte_of(q.instr, B_OP);
        b1      = byte_of(q.instr, B_1);
        diff    = q.acc_a - q.acc_b;
        hit     = 1'b1;
        rd_word = '0;
        unique case (i_paddr)
            REG_CTRL: begin
                rd_word[CTRL_XMEM] = q.xmem;
                rd_word[CTRL_IND]  = q.ind;
                rd_word[CTRL_LEN_H:CTRL_LEN_L] = q.len;
                rd_word[CTRL_BUSY] = busy;
                rd_word[CTRL_ERR]  = q.err;
            end
            REG_INSTR: rd_word = q.instr;
            REG_EA:    rd_word = {8'h00, q.ea};
            REG_ACC:   rd_word = {16'h0000, q.acc_b, q.acc_a};
            REG_CCR:   rd_word = {24'h000000, q.condition_code_register};
            REG_PC:    rd_word = {16'h0000, q.pc};
            REG_SP:    rd_word = {16'h0000, q.sp};
            REG_PAGE:  rd_word = {24'h000000, q.page};
            default:   hit = 1'b0;
        endcase
        // APB: one wait state, commit on the ready edge
        d.pready = apb_acc & ~q.pready;
        if (apb_acc & ~q.pready) begin
            d.prdata  = i_pwrite ? 32'h00000000 : rd_word;
            d.pslverr = ~hit | (i_pwrite & busy);
        end
        if (apb_acc & q.pready & i_pwrite & ~q.pslverr) begin
            unique case (i_paddr)
                REG_CTRL: begin
                    d.xmem = i_pwdata[CTRL_XMEM];
                    d.ind  = i_pwdata[CTRL_IND];
                    d.len  = i_pwdata[CTRL_LEN_H:CTRL_LEN_L];
                    if (i_pwdata[CTRL_START]) begin
                        d.st  = ST_EXEC;
                        d.err = 1'b0;
                    end
                end
                REG_INSTR: d.instr = i_pwdata;
                REG_EA:    d.ea    = i_pwdata[23:0];
                REG_ACC: begin
                    d.acc_a = i_pwdata[7:0];
                    d.acc_b = i_pwdata[15:8];
                end
                REG_CCR:   d.condition_code_register  = i_pwdata[7:0];
                REG_PC:    d.pc   = i_pwdata[15:0];
                REG_SP:    d.sp   = i_pwdata[15:0];
                REG_PAGE:  d.page = i_pwdata[7:0];
                default: ;
            endcase
        end
        // Memory request drops on acknowledge
        d.done = 1'b0;
        if (mem_fin) begin
            d.mem_req = 1'b0;
        end
        unique case (q.st)
            ST_IDLE: ;
            ST_EXEC: begin
                d.st   = ST_IDLE;
                d.done = 1'b1;
                d.irq_hold = 1'b0;
                unique case (opc)
                    OP_BR_OVF: begin
                        if (q.condition_code_register[CCR_V]) begin
                            d.pc = q.pc + BR_STEP + {{8{b1[7]}}, b1};
                        end else begin
                            d.pc = q.pc + BR_STEP;
                        end
                    end
                    OP_PREFIX: begin
                        if (b1 == OP_CMP_AB) begin
                            d.condition_code_register[CCR_N] = diff[7];
                            d.condition_code_register[CCR_Z] = (diff == 8'h00);
                            d.condition_code_register[CCR_V] = (q.acc_a[7] & ~q.acc_b[7] & ~diff[7])
                                         | (~q.acc_a[7] & q.acc_b[7] & diff[7]);
                            d.condition_code_register[CCR_C] = (~q.acc_a[7] & q.acc_b[7])
                                         | (q.acc_b[7] & diff[7])
                                         | (diff[7] & ~q.acc_a[7]);
                            d.pc = q.pc + INH2_STEP;
                        end else begin
                            d.err = 1'b1;
                        end
                    end
                    OP_FLAG_AND: begin
                        // carry and mask clears use this
                        d.condition_code_register = q.condition_code_register & b1;
                        d.pc  = q.pc + IMM_STEP;
                        d.irq_hold = q.condition_code_register[CCR_I] & ~b1[CCR_I];
                    end
                    OP_CALL_EXT: begin
                        d.rtn    = q.pc + CALL_EXT_LEN;
                        d.tgt    = {b1, byte_of(q.instr, B_2)};
                        d.pg_new = byte_of(q.instr, B_3);
                        d.sp     = q.sp - RTN_BYTES;
                        d.st     = ST_PUSH_H;
                        d.done   = 1'b0;
                        d.irq_hold = q.irq_hold;
                    end
                    OP_CALL_IDX: begin
                        d.rtn  = q.pc + 16'(q.len);
                        d.done = 1'b0;
                        d.irq_hold = q.irq_hold;
                        if (q.ind) begin
                            d.st = ST_IND_HI;
                        end else begin
                            d.tgt    = q.ea[15:0];
                            d.pg_new = q.ea[23:16];
                            d.sp     = q.sp - RTN_BYTES;
                            d.st     = ST_PUSH_H;
                        end
                    end
                    default: d.err = 1'b1;
                endcase
            end
            ST_IND_HI: begin
                d.mem_req  = ~mem_fin;
                d.mem_we   = 1'b0;
                d.mem_addr = q.ea[15:0];
                if (mem_fin) begin
                    d.tgt[15:8] = i_mem_rdata;
                    d.st        = ST_IND_LO;
                end
            end
            ST_IND_LO: begin
                d.mem_req  = ~mem_fin;
                d.mem_addr = q.ea[15:0] + PTR_NEXT;
                if (mem_fin) begin
                    d.tgt[7:0] = i_mem_rdata;
                    d.st       = ST_IND_PG;
                end
            end
            ST_IND_PG: begin
                d.mem_req  = ~mem_fin;
                d.mem_addr = q.ea[15:0] + PTR_PAGE;
                if (mem_fin) begin
                    d.pg_new = i_mem_rdata;
                    d.sp     = q.sp - RTN_BYTES;
                    d.st     = ST_PUSH_H;
                end
            end
            // high byte at the stack pointer
            ST_PUSH_H: begin
                d.mem_req   = ~mem_fin;
                d.mem_we    = 1'b1;
                d.mem_addr  = q.sp;
                d.mem_wdata = q.rtn[15:8];
                if (mem_fin) begin
                    d.st = ST_PUSH_L;
                end
            end
            ST_PUSH_L: begin
                d.mem_req   = ~mem_fin;
                d.mem_we    = 1'b1;
                d.mem_addr  = q.sp + PTR_NEXT;
                d.mem_wdata = q.rtn[7:0];
                if (mem_fin) begin
                    d.sp = q.sp - PAGE_BYTES;
                    d.st = ST_PUSH_P;
                end
            end
            ST_PUSH_P: begin
                d.mem_req   = ~mem_fin;
                d.mem_we    = 1'b1;
                d.mem_addr  = q.sp;
                d.mem_wdata = q.page;
                if (mem_fin) begin
                    // page register only with expanded memory
                    if (q.xmem) begin
                        d.page = q.pg_new;
                    end
                    d.pc       = q.tgt;
                    d.st       = ST_IDLE;
                    d.done     = 1'b1;
                    d.irq_hold = 1'b0;
                end
            end
        endcase
        d.mask_dly = q.condition_code_register[CCR_I];
        d.grant    = i_irq_pending & ~q.mask_dly & ~q.irq_hold & ~busy;
    end
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q          <= '0;
            q.condition_code_register      <= CCR_RST;
            q.mask_dly <= 1'b1;
        end else begin
            q <= d;
        end
    end
    assign o_pready    = q.pready;
    assign o_prdata    = q.prdata;
    assign o_pslverr   = q.pslverr;
    assign o_mem_req   = q.mem_req;
    assign o_mem_we    = q.mem_we;
    assign o_mem_addr  = q.mem_addr;
    assign o_mem_wdata = q.mem_wdata;
    assign o_irq_grant = q.grant;
    assign o_done      = q.done;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    a_br_taken: assert property (
        (q.st == ST_EXEC && opc == OP_BR_OVF && q.condition_code_register[CCR_V])
        |=> q.pc == $past(q.pc) + BR_STEP + {{8{$past(b1[7])}}, $past(b1)})
        else $error("overflow branch target wrong");
    a_br_flags: assert property (
        (q.st == ST_EXEC && opc == OP_BR_OVF) |=> $stable(q.condition_code_register))
        else $error("branch changed flags");
    a_cmp_keeps: assert property (
        (q.st == ST_EXEC && opc == OP_PREFIX)
        |=> $stable(q.acc_a) && $stable(q.acc_b))
        else $error("compare changed accumulators");
    a_cmp_zero_carry: assert property (
        (q.st == ST_EXEC && opc == OP_PREFIX && b1 == OP_CMP_AB)
        |=> q.condition_code_register[CCR_Z] == ($past(q.acc_a) == $past(q.acc_b))
            && q.condition_code_register[CCR_C] == ($past(q.acc_a) < $past(q.acc_b)))
        else $error("compare zero or carry wrong");
    a_and_mask: assert property (
        (q.st == ST_EXEC && opc == OP_FLAG_AND)
        |=> q.condition_code_register == ($past(q.condition_code_register) & $past(b1)))
        else $error("flags AND result wrong");
    a_ret_high: assert property (
        (q.st == ST_PUSH_H && q.mem_req)
        |-> q.mem_we && q.mem_addr == q.sp && q.mem_wdata == q.rtn[15:8])
        else $error("return high byte misplaced");
    a_push_order: assert property (
        (q.st == ST_PUSH_L && mem_fin)
        |=> q.st == ST_PUSH_P && q.sp == $past(q.sp) - PAGE_BYTES)
        else $error("page push order wrong");
    a_call_finish: assert property (
        (q.st == ST_PUSH_P && mem_fin && q.xmem)
        |=> q.pc == $past(q.tgt) && q.page == $past(q.pg_new) && o_done)
        else $error("call did not finish");
    a_mask_late: assert property (
        $fell(q.condition_code_register[CCR_I]) |-> q.mask_dly ##1 !q.mask_dly)
        else $error("mask clear not delayed");
    a_ind_order: assert property (
        (q.st == ST_IND_HI && mem_fin) |=> q.st == ST_IND_LO ##[1:1000] q.st == ST_IND_PG)
        else $error("pointer read order wrong");

endmodule // exec_unit

/* File: test/exec_mem_model.sv */
// Byte memory on the far side of the unit, answering after a chosen delay
`timescale 1ns/10ps

module exec_mem_model (
    // Clock and delay setting
    input  wire logic        i_clock,
    input  wire logic [3:0]  i_delay,
    // Memory bus
    input  wire logic        i_mem_req,
    input  wire logic        i_mem_we,
    input  wire logic [15:0] i_mem_addr,
    input  wire logic [7:0]  i_mem_wdata,
    output logic             o_mem_ack,
    output logic [7:0]       o_mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [3:0] wait_q;

    initial begin
        o_mem_ack   = 1'b0;
        o_mem_rdata = 8'hA5;
        wait_q      = 4'h0;
    end

    always @(posedge i_clock) begin
        o_mem_ack   <= 1'b0;
        // Idle data line toggles so a stale byte never looks like an answer
        o_mem_rdata <= ~o_mem_rdata;
        if (i_mem_req && o_mem_ack && i_mem_we) begin
            mem[i_mem_addr] <= i_mem_wdata;
        end
        if (i_mem_req && !o_mem_ack) begin
            if (wait_q >= i_delay) begin
                o_mem_ack   <= 1'b1;
                o_mem_rdata <= i_mem_we ? ~o_mem_rdata : mem[i_mem_addr];
                wait_q      <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // exec_mem_model

/* File: test/exec_unit_test.sv */
// Self-checking bench for the branch, call, compare and flag-clear unit
`timescale 1ns/10ps

module exec_unit_test;
    import exec_pkg::*;

    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
        logic        err;
    } note_type;

    logic        i_clock, i_rst_b, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [7:0]  i_paddr, o_mem_wdata, mem_rdata, a, b, r, m, pre;
    logic [31:0] i_pwdata, o_prdata, lfsr;
    logic        o_mem_req, o_mem_we, mem_ack, irq_pending, o_irq_grant, o_done;
    logic [15:0] o_mem_addr, pc, tgt;
    logic [3:0]  delay;
    note_type    notes[$];
    note_type    nt;
    int          fails, check_count;

    exec_unit exec_unit_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .i_irq_pending(irq_pending), .o_irq_grant(o_irq_grant), .o_done(o_done));
    exec_mem_model exec_mem_model_inst (.i_clock(i_clock), .i_delay(delay),
        .i_mem_req(o_mem_req), .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr),
        .i_mem_wdata(o_mem_wdata), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));

    function automatic logic [31:0] next_rand(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk32(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        chk32(what, {24'h0, exp}, {24'h0, got});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; the expected answer is queued for the monitor
    task automatic apb(logic wr, logic [7:0] ad, logic [31:0] d, logic [31:0] mk, logic er);
        int n;
        n = 0;
        notes.push_back('{d, mk, er});
        @(posedge i_clock);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= wr;
        i_paddr   <= ad;
        i_pwdata  <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin
            @(negedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        @(posedge i_clock);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(logic [7:0] ad, logic [31:0] d);
        apb(1'b1, ad, d, 32'h0, 1'b0);
    endtask

    task automatic rd(logic [7:0] ad, logic [31:0] e);
        apb(1'b0, ad, e, 32'hFFFF_FFFF, 1'b0);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge i_clock);
            n++;
        end while (o_done !== 1'b1 && n < 400);
        if (n >= 400) fails++;
    endtask

    task automatic run(logic [31:0] instr, logic [31:0] ctrl);
        wr(REG_INSTR, instr);
        wr(REG_CTRL, ctrl | 32'h1);
        wait_done();
    endtask

    // Answer monitor: takes the oldest note at each completed transfer
    always @(posedge i_clock) begin
        if (i_psel && i_penable && o_pready === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            chk32("prdata", nt.exp & nt.mask, o_prdata & nt.mask);
            chk8("pslverr", {7'h0, nt.err}, {7'h0, o_pslverr});
        end
    end

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    initial begin
        #(4 * 20000);
        fails++;
        end_sim();
    end

    initial begin
        {i_rst_b, i_psel, i_penable, i_pwrite, irq_pending} = 5'h0;
        i_paddr     = 8'h0;
        i_pwdata    = 32'h0;
        delay       = 4'h0;
        lfsr        = 32'h765d;
        fails       = 0;
        check_count = 0;
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        rd(REG_CCR, {24'h0, CCR_RST});
        rd(REG_SP, 32'h0);
        apb(1'b0, 8'h3C, 32'h0, 32'hFFFF_FFFF, 1'b1);
        for (int v = 0; v < 2; v++) begin
            lfsr = next_rand(lfsr);
            pre  = CCR_RST | (v[0] ? 8'h02 : 8'h00);
            pc   = lfsr[31:16];
            wr(REG_CCR, {24'h0, pre});
            wr(REG_PC, {16'h0, pc});
            run({16'h0, lfsr[7:0], OP_BR_OVF}, 32'h0);
            tgt = pc + BR_STEP + (v[0] ? {{8{lfsr[7]}}, lfsr[7:0]} : 16'h0);
            rd(REG_PC, {16'h0, tgt});
            rd(REG_CCR, {24'h0, pre});
        end
        for (int i = 0; i < 8; i++) begin
            lfsr = next_rand(lfsr);
            a    = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : (i == 2) ? 8'h7F : lfsr[7:0];
            b    = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : lfsr[15:8];
            r    = a - b;
            pre  = {4'hD, lfsr[19:16]};
            wr(REG_CCR, {24'h0, pre});
            wr(REG_ACC, {16'h0, b, a});
            run({16'h0, OP_CMP_AB, OP_PREFIX}, 32'h0);
            m = {4'hD, r[7], r == 8'h0, a[7] & ~b[7] & ~r[7] | ~a[7] & b[7] & r[7],
                 ~a[7] & b[7] | b[7] & r[7] | r[7] & ~a[7]};
            rd(REG_CCR, {24'h0, m});
            rd(REG_ACC, {16'h0, b, a});
        end
        for (int i = 0; i < 3; i++) begin
            lfsr = next_rand(lfsr);
            m    = (i == 0) ? 8'hFE : (i == 1) ? 8'hEF : lfsr[7:0];
            wr(REG_CCR, 32'hDF);
            run({16'h0, m, OP_FLAG_AND}, 32'h0);
            rd(REG_CCR, {24'h0, 8'hDF & m});
        end
        wr(REG_CCR, {24'h0, CCR_RST});
        irq_pending <= 1'b1;
        run({16'h0, 8'hEF, OP_FLAG_AND}, 32'h0);
        chk8("irq_grant", 8'h0, {7'h0, o_irq_grant});
        repeat (3) @(negedge i_clock);
        chk8("irq_grant", 8'h0, {7'h0, o_irq_grant});
        run({16'h0, 8'h00, OP_BR_OVF}, 32'h0);
        repeat (2) @(negedge i_clock);
        chk8("irq_grant", 8'h1, {7'h0, o_irq_grant});
        @(posedge i_clock);
        irq_pending <= 1'b0;
        delay <= 4'h6;
        wr(REG_SP, 32'h2000);
        wr(REG_PC, 32'h1000);
        wr(REG_PAGE, 32'h5A);
        wr(REG_EA, 32'h0037_4321);
        wr(REG_INSTR, {8'h37, 8'h21, 8'h43, OP_CALL_EXT});
        wr(REG_CTRL, 32'h3);
        apb(1'b0, REG_CTRL, 32'h100, 32'h100, 1'b0);
        apb(1'b1, REG_PC, 32'h0, 32'h0, 1'b1);
        wait_done();
        chk8("stack hi", 8'h10, exec_mem_model_inst.mem[16'h1FFE]);
        chk8("stack lo", 8'h04, exec_mem_model_inst.mem[16'h1FFF]);
        chk8("stack page", 8'h5A, exec_mem_model_inst.mem[16'h1FFD]);
        rd(REG_SP, 32'h1FFD);
        rd(REG_PC, 32'h4321);
        rd(REG_PAGE, 32'h37);
        rd(REG_CCR, 32'hC0);
        delay <= 4'h0;
        exec_mem_model_inst.mem[16'h3000] = 8'h65;
        exec_mem_model_inst.mem[16'h3001] = 8'h87;
        exec_mem_model_inst.mem[16'h3002] = 8'h99;
        wr(REG_SP, 32'h2400);
        wr(REG_PC, 32'h0800);
        wr(REG_EA, 32'h3000);
        run({24'h0, OP_CALL_IDX}, 32'h44);
        chk8("stack hi", 8'h08, exec_mem_model_inst.mem[16'h23FE]);
        chk8("stack lo", 8'h04, exec_mem_model_inst.mem[16'h23FF]);
        chk8("stack page", 8'h37, exec_mem_model_inst.mem[16'h23FD]);
        rd(REG_PC, 32'h6587);
        rd(REG_PAGE, 32'h37);
        wr(REG_SP, 32'h2000);
        wr(REG_EA, 32'h0022_1234);
        run({24'h0, OP_CALL_IDX}, 32'h32);
        chk8("stack hi", 8'h65, exec_mem_model_inst.mem[16'h1FFE]);
        chk8("stack lo", 8'h8A, exec_mem_model_inst.mem[16'h1FFF]);
        chk8("stack page", 8'h37, exec_mem_model_inst.mem[16'h1FFD]);
        rd(REG_SP, 32'h1FFD);
        rd(REG_PC, 32'h1234);
        rd(REG_PAGE, 32'h22);
        run(32'h0, 32'h0);
        rd(REG_CTRL, 32'h200);
        end_sim();
    end
endmodule // exec_unit_test
